//--- src/ovuv_map.vh
`ifndef OVUV_MAP_VH
`define OVUV_MAP_VH
// Register byte addresses: printed offsets are not word aligned, so index times four.
`define OVUV_IDX_OV_A 16'hfe26
`define OVUV_IDX_OV_B 16'hfe27
`define OVUV_IDX_UV_A 16'hfe28
`define OVUV_IDX_STATUS 16'hfe2f
`define OVUV_ADDR_OV_A 18'h3f898
`define OVUV_ADDR_OV_B 18'h3f89c
`define OVUV_ADDR_UV_A 18'h3f8a0
`define OVUV_ADDR_STATUS 18'h3f8bc
`define OVUV_RST_OV 8'h00
`define OVUV_RST_UV 8'h00
`define OVUV_OV_DB_MSB 7
`define OVUV_OV_DB_LSB 6
`define OVUV_OV_TH_MSB 5
`define OVUV_OV_TH_LSB 0
`define OVUV_UV_DB_BIT 7
`define OVUV_UV_TH_MSB 6
`define OVUV_UV_TH_LSB 0
`define OVUV_VS_WIDTH 12
`define OVUV_CLK_HZ 25000000
// Debounce times in nanoseconds, and milliseconds for the long one.
`define OVUV_T_OV1_NS 960
`define OVUV_T_OV2_NS 2240
`define OVUV_T_OV3_NS 8000
`define OVUV_T_UV_MS 100
`define OVUV_CYC_OV1 ((`OVUV_T_OV1_NS * (`OVUV_CLK_HZ / 1000000) + 999) / 1000)
`define OVUV_CYC_OV2 ((`OVUV_T_OV2_NS * (`OVUV_CLK_HZ / 1000000) + 999) / 1000)
`define OVUV_CYC_OV3 ((`OVUV_T_OV3_NS * (`OVUV_CLK_HZ / 1000000) + 999) / 1000)
`define OVUV_CYC_UV (`OVUV_T_UV_MS * (`OVUV_CLK_HZ / 1000))
`endif

//--- src/ovuv_debounce.v
`timescale 1ns/10ps
`include "ovuv_map.vh"
module ovuv_debounce (
  input wire sys_clk,
  input wire rst_n,
  input wire fault,
  input wire [21:0] limit,
  output reg flag
);
  reg [21:0] count;
  // A limit of zero passes the fault straight to the registered flag.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= 22'h000000;
      flag <= 1'b0;
    end else if (!fault) begin
      count <= 22'h000000;
      flag <= 1'b0;
    end else if (count >= limit) begin
      flag <= 1'b1;
    end else begin
      count <= count + 22'h000001;
    end
  end
endmodule

//--- src/ovuv_fault_flags.v
`timescale 1ns/10ps
`include "ovuv_map.vh"
// Function
// - Two-bit overvoltage debounce code selects 0/0.96/2.24/8 us.
// - Six-bit field drives comparator threshold code.
// - Threshold code maps linearly 0.75 V to 1.5 V.
// - Undervoltage debounce bit: none or 100 ms.
// - Undervoltage when threshold exceeds sensed seven MSBs.
// - Undervoltage threshold step is 12.5 mV.
// - Zero undervoltage threshold keeps flag cleared.
// - Compare against voltage-sense converter output.
module ovuv_fault_flags (
  input wire sys_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire overvoltage_cmp_a,
  input wire overvoltage_cmp_b,
  input wire [11:0] sensed_voltage_channel_a,
  output wire [5:0] overvoltage_threshold_a,
  output wire [5:0] overvoltage_threshold_b,
  output wire overvoltage_channel_a,
  output wire overvoltage_channel_b,
  output wire undervoltage_channel_a
);
  reg [7:0] overvolt_setting_ch_a;
  reg [7:0] overvolt_setting_ch_b;
  reg [7:0] undervolt_setting_ch_a;
  reg [7:0] next_overvolt_setting_ch_a;
  reg [7:0] next_overvolt_setting_ch_b;
  reg [7:0] next_undervolt_setting_ch_a;
  reg [31:0] next_prdata;
  reg uv_fault;
  wire [2:0] sel;
  wire wr_access;
  wire rd_setup;
  wire [2:0] flags;
  wire [6:0] uv_th;
  wire [6:0] vs_msbs;
  wire [1:0] ov_code_a;
  wire [1:0] ov_code_b;
  wire [21:0] ov_lim_a;
  wire [21:0] ov_lim_b;
  wire [21:0] uv_lim;

  // Register select codes produced by the address decode.
  localparam [2:0] SEL_NONE = 3'b000;
  localparam [2:0] SEL_OV_A = 3'b001;
  localparam [2:0] SEL_OV_B = 3'b010;
  localparam [2:0] SEL_UV_A = 3'b011;
  localparam [2:0] SEL_STATUS = 3'b100;

  // Counts are reckoned as integers and then cut to the counter width on purpose.
  localparam integer CYC_OV1_M1 = `OVUV_CYC_OV1 - 1;
  localparam integer CYC_OV2_M1 = `OVUV_CYC_OV2 - 1;
  localparam integer CYC_OV3_M1 = `OVUV_CYC_OV3 - 1;
  localparam integer CYC_UV_M1 = `OVUV_CYC_UV - 1;
  localparam [21:0] LIM_OV1 = CYC_OV1_M1[21:0];
  localparam [21:0] LIM_OV2 = CYC_OV2_M1[21:0];
  localparam [21:0] LIM_OV3 = CYC_OV3_M1[21:0];
  localparam [21:0] LIM_UV = CYC_UV_M1[21:0];

  function [2:0] reg_sel;
    input [31:0] addr;
    begin
      if (addr[31:18] != 14'h0000) begin
        reg_sel = SEL_NONE;
      end else begin
        case (addr[17:0])
          `OVUV_ADDR_OV_A: reg_sel = SEL_OV_A;
          `OVUV_ADDR_OV_B: reg_sel = SEL_OV_B;
          `OVUV_ADDR_UV_A: reg_sel = SEL_UV_A;
          `OVUV_ADDR_STATUS: reg_sel = SEL_STATUS;
          default: reg_sel = SEL_NONE;
        endcase
      end
    end
  endfunction

  function [31:0] pad_byte;
    input [7:0] value;
    begin
      pad_byte = {24'h000000, value};
    end
  endfunction

  function [1:0] ov_code;
    input [7:0] setting;
    begin
      ov_code = setting[`OVUV_OV_DB_MSB:`OVUV_OV_DB_LSB];
    end
  endfunction

  function [5:0] ov_threshold;
    input [7:0] setting;
    begin
      ov_threshold = setting[`OVUV_OV_TH_MSB:`OVUV_OV_TH_LSB];
    end
  endfunction

  // Each limit is one less than the sample count, since the counter starts at zero.
  function [21:0] ov_limit;
    input [1:0] code;
    begin
      case (code)
        2'b00: ov_limit = 22'h000000;
        2'b01: ov_limit = LIM_OV1;
        2'b10: ov_limit = LIM_OV2;
        default: ov_limit = LIM_OV3;
      endcase
    end
  endfunction

  function uv_detect;
    input [6:0] threshold;
    input [6:0] sensed;
    begin
      uv_detect = (threshold != 7'h00) && (threshold > sensed);
    end
  endfunction

  assign sel = reg_sel(paddr);
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign flags = {undervoltage_channel_a, overvoltage_channel_b, overvoltage_channel_a};
  // No wait states: every access phase completes in its first cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel == SEL_NONE);

  // The status word is read-only, so a write to it falls through to the default.
  always @* begin
    next_overvolt_setting_ch_a = overvolt_setting_ch_a;
    next_overvolt_setting_ch_b = overvolt_setting_ch_b;
    next_undervolt_setting_ch_a = undervolt_setting_ch_a;
    if (wr_access) begin
      case (sel)
        SEL_OV_A: next_overvolt_setting_ch_a = pwdata[7:0];
        SEL_OV_B: next_overvolt_setting_ch_b = pwdata[7:0];
        SEL_UV_A: next_undervolt_setting_ch_a = pwdata[7:0];
        default: next_overvolt_setting_ch_a = overvolt_setting_ch_a;
      endcase
    end
  end

  // Read data is captured in the setup cycle, so it already stands in the access phase.
  always @* begin
    next_prdata = prdata;
    if (rd_setup) begin
      case (sel)
        SEL_OV_A: next_prdata = pad_byte(overvolt_setting_ch_a);
        SEL_OV_B: next_prdata = pad_byte(overvolt_setting_ch_b);
        SEL_UV_A: next_prdata = pad_byte(undervolt_setting_ch_a);
        SEL_STATUS: next_prdata = {29'h00000000, flags};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      overvolt_setting_ch_a <= `OVUV_RST_OV;
      overvolt_setting_ch_b <= `OVUV_RST_OV;
      undervolt_setting_ch_a <= `OVUV_RST_UV;
      prdata <= 32'h00000000;
    end else begin
      overvolt_setting_ch_a <= next_overvolt_setting_ch_a;
      overvolt_setting_ch_b <= next_overvolt_setting_ch_b;
      undervolt_setting_ch_a <= next_undervolt_setting_ch_a;
      prdata <= next_prdata;
    end
  end

  // Code 0x00 is 0.75 V and 0x3f is 1.5 V in the analog comparator.
  assign overvoltage_threshold_a = ov_threshold(overvolt_setting_ch_a);
  assign overvoltage_threshold_b = ov_threshold(overvolt_setting_ch_b);
  assign ov_code_a = ov_code(overvolt_setting_ch_a);
  assign ov_code_b = ov_code(overvolt_setting_ch_b);
  assign ov_lim_a = ov_limit(ov_code_a);
  assign ov_lim_b = ov_limit(ov_code_b);
  assign uv_lim = undervolt_setting_ch_a[`OVUV_UV_DB_BIT] ? LIM_UV : 22'h000000;

  // One threshold step equals one step of the upper seven sense bits, 12.5 mV.
  assign uv_th = undervolt_setting_ch_a[`OVUV_UV_TH_MSB:`OVUV_UV_TH_LSB];
  assign vs_msbs = sensed_voltage_channel_a[11:5];
  // Registering the compare keeps the magnitude compare off the debounce counter's path.
  always @(posedge sys_clk) begin
    if (!rst_n)
      uv_fault <= 1'b0;
    else
      uv_fault <= uv_detect(uv_th, vs_msbs);
  end

  ovuv_debounce u_deb_ov_a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fault(overvoltage_cmp_a),
    .limit(ov_lim_a),
    .flag(overvoltage_channel_a)
  );

  ovuv_debounce u_deb_ov_b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fault(overvoltage_cmp_b),
    .limit(ov_lim_b),
    .flag(overvoltage_channel_b)
  );

  // Zero threshold forces the registered fault low one cycle later, so the flag clears the cycle after that.
  ovuv_debounce u_deb_uv_a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fault(uv_fault),
    .limit(uv_lim),
    .flag(undervoltage_channel_a)
  );
endmodule

//--- bench/ovuv_checker.sv
`timescale 1ns/10ps
`include "ovuv_map.vh"
module ovuv_checker (
  input wire sys_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire overvoltage_cmp_a,
  input wire [11:0] sensed_voltage_channel_a,
  input wire [5:0] overvoltage_threshold_a,
  input wire overvoltage_channel_a,
  input wire overvoltage_channel_b,
  input wire undervoltage_channel_a
);
  reg [7:0] ova;
  reg [7:0] uv;
  reg [7:0] n;
  wire w = psel && penable && pwrite;
  wire [7:0] lim = ova[7] ? (ova[6] ? 8'(`OVUV_CYC_OV3) : 8'(`OVUV_CYC_OV2)) : 8'(`OVUV_CYC_OV1);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // The run of high comparator samples saturates so a long fault cannot wrap it.
  always @(posedge sys_clk) begin
    if (w && paddr == `OVUV_ADDR_OV_A) ova <= pwdata[7:0];
    if (w && paddr == `OVUV_ADDR_UV_A) uv <= pwdata[7:0];
    n <= overvoltage_cmp_a ? n + {7'h00, ~&n} : 8'h00;
    if (!rst_n) begin
      ova <= 8'h00;
      uv <= 8'h00;
    end
  end
  property p_thr; w && paddr == `OVUV_ADDR_OV_A |=> overvoltage_threshold_a == $past(pwdata[5:0]); endproperty
  a_thr: assert property (p_thr) else $error("threshold");
  property p_ov0; (overvoltage_cmp_a && ova[7:6] == 2'b00) [*3] |-> overvoltage_channel_a; endproperty
  a_ov0: assert property (p_ov0) else $error("ov zero");
  property p_clr; !overvoltage_cmp_a [*3] |-> !overvoltage_channel_a; endproperty
  a_clr: assert property (p_clr) else $error("ov clear");
  property p_cnt; $rose(overvoltage_channel_a) && ova[7:6] != 2'b00 |-> n == lim; endproperty
  a_cnt: assert property (p_cnt) else $error("ov time");
  property p_uvz; uv[6:0] == 7'h00 [*3] |-> !undervoltage_channel_a; endproperty
  a_uvz: assert property (p_uvz) else $error("uv zero");
  property p_uv; (uv[6:0] > sensed_voltage_channel_a[11:5] && !uv[7]) [*4] |-> undervoltage_channel_a; endproperty
  a_uv: assert property (p_uv) else $error("uv set");
  property p_uvdb; $rose(undervoltage_channel_a) |-> !$past(uv[7]); endproperty
  a_uvdb: assert property (p_uvdb) else $error("uv time");
  property p_uvok; uv[6:0] <= sensed_voltage_channel_a[11:5] [*3] |-> !undervoltage_channel_a; endproperty
  a_uvok: assert property (p_uvok) else $error("uv false");
  c_long: cover property ($rose(overvoltage_channel_a) && ova[7:6] == 2'b11);
  c_b: cover property ($rose(overvoltage_channel_b));
  c_uv: cover property ($rose(undervoltage_channel_a));
endmodule
bind ovuv_fault_flags ovuv_checker u_chk (.*);

//--- bench/ovuv_far_side.sv
`timescale 1ns/10ps
module ovuv_far_side (
  input wire sys_clk,
  input wire [5:0] overvoltage_threshold_a,
  input wire [5:0] overvoltage_threshold_b,
  input int mv,
  output logic overvoltage_cmp_a = 1'b0,
  output logic overvoltage_cmp_b = 1'b0,
  output logic [11:0] sensed_voltage_channel_a = 12'h000
);
  // Outputs are registered so they only move just after an edge.
  always @(posedge sys_clk) begin
    overvoltage_cmp_a <= mv * 63 > 47250 + overvoltage_threshold_a * 750;
    overvoltage_cmp_b <= mv * 63 > 47250 + overvoltage_threshold_b * 750;
    sensed_voltage_channel_a <= 12'(mv * 64 / 25);
  end
endmodule

//--- bench/testbench.sv
`timescale 1ns/10ps
`include "ovuv_map.vh"
module testbench;
  logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, s = 32'hd69c;
  wire [31:0] prdata;
  wire pready, pslverr, overvoltage_cmp_a, overvoltage_cmp_b;
  wire overvoltage_channel_a, overvoltage_channel_b, undervoltage_channel_a;
  wire [5:0] overvoltage_threshold_a, overvoltage_threshold_b;
  wire [11:0] sensed_voltage_channel_a;
  int mv = 0, num_errors = 0, checked = 0, r;
  int lim[4] = '{0, `OVUV_CYC_OV1, `OVUV_CYC_OV2, `OVUV_CYC_OV3};
  logic [31:0] ad[4] = '{`OVUV_ADDR_OV_A, `OVUV_ADDR_OV_B, `OVUV_ADDR_UV_A, 32'h10};
  logic [31:0] q[$];
  ovuv_fault_flags u_dut (.*);
  ovuv_far_side u_far (.*);
  always #20 sys_clk = ~sys_clk;
  function logic [31:0] xs;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic wr, input logic [31:0] a, d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [31:0] a, e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task results;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (psel && penable && pready && !pwrite) chk(prdata, q.pop_front());
    if (psel && penable && pready) chk(pslverr, paddr == ad[3]);
  end
  initial begin
    #400000;
    num_errors++;
    results;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (ad[i]) rd(ad[i], 32'h0);
    foreach (ad[i]) begin
      r = xs() & 32'hff;
      apb(1'b1, ad[i], r);
      rd(ad[i], i < 3 ? r : 0);
    end
    $display("register test done");
    apb(1'b1, ad[2], 32'h0);
    for (int c = 0; c < 4; c++) begin
      r = xs() % 64;
      mv <= 0;
      apb(1'b1, ad[0], c << 6 | r);
      apb(1'b1, ad[1], c << 6 | r);
      mv <= 751 + r * 12;
      cyc(c ? lim[c] - 1 : 0);
      if (c) rd(`OVUV_ADDR_STATUS, 32'h0);
      cyc(8);
      rd(`OVUV_ADDR_STATUS, 32'h3);
      mv <= 750 + r * 11;
      cyc(3);
      rd(`OVUV_ADDR_STATUS, 32'h0);
    end
    $display("overvoltage test done");
    apb(1'b1, ad[0], 32'h3f);
    apb(1'b1, ad[1], 32'h3f);
    r = xs() % 100 + 1;
    apb(1'b1, ad[2], r);
    mv <= (r - 1) * 25 / 2 + 6;
    cyc(6);
    rd(`OVUV_ADDR_STATUS, 32'h4);
    mv <= r * 25 / 2 + 6;
    cyc(6);
    rd(`OVUV_ADDR_STATUS, 32'h0);
    apb(1'b1, ad[2], r | 128);
    mv <= 0;
    cyc(9);
    rd(`OVUV_ADDR_STATUS, 32'h0);
    apb(1'b1, ad[2], 32'h0);
    cyc(6);
    rd(`OVUV_ADDR_STATUS, 32'h0);
    $display("undervoltage test done");
    results;
  end
endmodule
